// ===== design/acr_regs.sv
// register file, link slave and conversion sequencer of the converter
`timescale 1ns/10ps
`include "acr_cfg.svh"

// Notes on behaviour
// - every byte of a write frame to the slave address is acknowledged.
// - results are 12-bit two's complement in bits 15:4 of the word.
// - results clip at 7ff0h and 8000h, never wrap.
// - result reads zero from reset until the first conversion lands.
// - the four low result bits always read zero.
// - index 00h selects the read-only result, reset 0000h.
// - index 01h selects the read/write setup register, reset 8583h.
// - writing 1 to bit 15 starts one conversion only when powered down.
// - bit 15 reads 0 while converting, 1 when idle; resets to 1.
// - input select bits 14:12 route the multiplexer pairs.
// - without a multiplexer the input select stays at 000.
// - gain bits 11:9 pick the full-scale span, default 010.
// - bit 8 picks continuous (0) or single-shot (1, default).
// - rate bits 7:5 pick the conversion rate, default 100.
// - words travel high byte first, each byte msb first.
// - the register index is kept across read frames.
// - in continuous mode bit 15 reads 0.
module acr_regs #(
    parameter bit HAS_MUX = 1'b1,
    parameter int OSC_HZ = `ACR_OSC_HZ
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic osc_clk_i,
    input wire logic [15:0] sample_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic [2:0] input_select_o,
    output logic [2:0] gain_range_select_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] conv_cycles(input logic [2:0] rate);
        int sps;
        sps = `ACR_SPS_6;
        unique case (rate)
            3'h0: sps = `ACR_SPS_0;
            3'h1: sps = `ACR_SPS_1;
            3'h2: sps = `ACR_SPS_2;
            3'h3: sps = `ACR_SPS_3;
            3'h4: sps = `ACR_SPS_4;
            3'h5: sps = `ACR_SPS_5;
            3'h6, 3'h7: sps = `ACR_SPS_6;
        endcase
        // longest time: round down, but never below one cycle
        conv_cycles = (OSC_HZ / sps) < 1 ? 32'd1 : 32'(OSC_HZ / sps);
    endfunction

    // clip a wide signed code to 12 bits and left-justify it
    function automatic logic [15:0] clip_code(input logic [15:0] raw);
        logic signed [15:0] s;
        logic [11:0] c;
        s = signed'(raw);
        if (s > signed'(16'h07ff)) begin
            c = `ACR_CODE_MAX;
        end else if (s < signed'(16'hf800)) begin
            c = `ACR_CODE_MIN;
        end else begin
            c = raw[11:0];
        end
        clip_code = {c, `ACR_LOW_ZERO};
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and link events
    // ----------------------------------------------------------------
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    always_ff @(posedge sys_clk_i) begin
        scl_sync_r <= {scl_sync_r[0], scl_i};
        sda_sync_r <= {sda_sync_r[0], sda_i};
        scl_d_r <= scl_sync_r[1];
        sda_d_r <= sda_sync_r[1];
    end

    logic scl_rise;
    logic scl_fall;
    logic frame_start;
    logic frame_stop;
    assign scl_rise = scl_sync_r[1] && !scl_d_r;
    assign scl_fall = !scl_sync_r[1] && scl_d_r;
    assign frame_start = scl_sync_r[1] && scl_d_r && !sda_sync_r[1] && sda_d_r;
    assign frame_stop = scl_sync_r[1] && scl_d_r && sda_sync_r[1] && !sda_d_r;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    localparam logic [15:0] SETUP_RST = `ACR_SETUP_RST;

    acr_pkg::acr_setup_type setup_r;
    logic busy_r;
    logic [15:0] result_r;
    logic [7:0] index_r;
    logic wr_setup;
    logic [15:0] wr_data;
    logic done_evt;
    logic [15:0] osc_result_r;

    logic read_flag;
    logic [15:0] setup_word;
    logic [15:0] read_word;
    assign read_flag = (setup_r.mode == `ACR_MODE_SINGLE) && !busy_r;
    assign setup_word = {read_flag, setup_r};
    assign read_word = (index_r == `ACR_IDX_SETUP) ? setup_word :
        (index_r == `ACR_IDX_RESULT) ? result_r : 16'h0000;

    logic start_ok;
    assign start_ok = wr_data[`ACR_FLAG_BIT] && !busy_r &&
        (wr_data[`ACR_MODE_BIT] == `ACR_MODE_SINGLE) &&
        (setup_r.mode == `ACR_MODE_SINGLE);

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            setup_r <= acr_pkg::acr_setup_type'(SETUP_RST[14:0]);
        end else if (wr_setup) begin
            setup_r <= acr_pkg::acr_setup_type'(wr_data[14:0]);
            if (!HAS_MUX) begin
                setup_r.input_select <= `ACR_MUX_FIXED;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            input_select_o <= SETUP_RST[14:12];
            gain_range_select_o <= SETUP_RST[11:9];
        end else begin
            input_select_o <= setup_r.input_select;
            gain_range_select_o <= setup_r.gain_range_select;
        end
    end

    // start wins: a new request is only taken while not busy
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            busy_r <= 1'b0;
        end else if (wr_setup && start_ok) begin
            busy_r <= 1'b1;
        end else if (done_evt) begin
            busy_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            result_r <= `ACR_RESULT_RST;
        end else if (done_evt) begin
            result_r <= osc_result_r;
        end
    end

    // ----------------------------------------------------------------
    // request crossing to the oscillator domain
    // ----------------------------------------------------------------
    // the request word is held stable until the toggle is seen; a second
    // setup write within two oscillator cycles may be merged
    acr_pkg::acr_request_type req_r;
    logic req_tog_r;
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            req_r <= '0;
            req_tog_r <= 1'b0;
        end else if (wr_setup) begin
            req_r.start <= start_ok;
            req_r.mode <= wr_data[`ACR_MODE_BIT];
            req_r.sample_rate_select <= wr_data[7:5];
            req_tog_r <= !req_tog_r;
        end
    end

    logic [1:0] osc_rst_r;
    logic [2:0] req_sync_r;
    always_ff @(posedge osc_clk_i) begin
        osc_rst_r <= {osc_rst_r[0], reset_n_i};
        req_sync_r <= {req_sync_r[1:0], req_tog_r};
    end

    logic osc_req;
    assign osc_req = req_sync_r[2] ^ req_sync_r[1];

    // ----------------------------------------------------------------
    // conversion sequencer, oscillator domain
    // ----------------------------------------------------------------
    logic conv_r;
    logic cont_r;
    logic [2:0] rate_r;
    logic [31:0] cnt_r;
    logic done_tog_r;
    logic conv_end;
    logic single_run;
    assign conv_end = conv_r && (cnt_r == 32'd1);
    // a setup write during a single-shot is dropped here so the running
    // conversion still ends and clears busy; rewrite once idle to apply it
    assign single_run = conv_r && !cont_r;

    always_ff @(posedge osc_clk_i) begin
        if (!osc_rst_r[1]) begin
            conv_r <= 1'b0;
            cont_r <= 1'b0;
            rate_r <= SETUP_RST[7:5];
            cnt_r <= 32'd0;
        end else if (osc_req && !single_run) begin
            cont_r <= (req_r.mode != `ACR_MODE_SINGLE);
            rate_r <= req_r.sample_rate_select;
            conv_r <= req_r.start || (req_r.mode != `ACR_MODE_SINGLE);
            cnt_r <= conv_cycles(req_r.sample_rate_select);
        end else if (conv_end) begin
            conv_r <= cont_r;
            cnt_r <= conv_cycles(rate_r);
        end else if (conv_r) begin
            cnt_r <= cnt_r - 32'd1;
        end
    end

    always_ff @(posedge osc_clk_i) begin
        if (!osc_rst_r[1]) begin
            osc_result_r <= 16'h0000;
            done_tog_r <= 1'b0;
        end else if (conv_end) begin
            osc_result_r <= clip_code(sample_i);
            done_tog_r <= !done_tog_r;
        end
    end

    logic [2:0] done_sync_r;
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            done_sync_r <= 3'h0;
        end else begin
            done_sync_r <= {done_sync_r[1:0], done_tog_r};
        end
    end
    assign done_evt = done_sync_r[2] ^ done_sync_r[1];

    // ----------------------------------------------------------------
    // link slave
    // ----------------------------------------------------------------
    acr_pkg::acr_link_state_type st_r;
    logic [7:0] sh_r;
    logic [3:0] bit_r;
    logic rw_r;
    logic hi_r;
    logic first_r;
    logic nack_r;
    logic [7:0] wr_hi_r;

    assign wr_setup = (st_r == acr_pkg::ACR_S_WDATA) && scl_fall &&
        (bit_r == 4'd8) && !first_r && !hi_r &&
        (index_r == `ACR_IDX_SETUP);
    assign wr_data = {wr_hi_r, sh_r};

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            st_r <= acr_pkg::ACR_S_IDLE;
            sh_r <= 8'h00;
            bit_r <= 4'd0;
            rw_r <= 1'b0;
            hi_r <= 1'b1;
            first_r <= 1'b1;
            nack_r <= 1'b0;
            wr_hi_r <= 8'h00;
            index_r <= `ACR_IDX_RESULT;
            sda_oe_n_o <= 1'b1;
        end else if (frame_start) begin
            st_r <= acr_pkg::ACR_S_ADDR;
            bit_r <= 4'd0;
            hi_r <= 1'b1;
            first_r <= 1'b1;
            sda_oe_n_o <= 1'b1;
        end else if (frame_stop) begin
            st_r <= acr_pkg::ACR_S_IDLE;
            sda_oe_n_o <= 1'b1;
        end else if (scl_rise) begin
            if (st_r == acr_pkg::ACR_S_ADDR || st_r == acr_pkg::ACR_S_WDATA) begin
                sh_r <= {sh_r[6:0], sda_sync_r[1]};
                bit_r <= bit_r + 4'd1;
            end else if (st_r == acr_pkg::ACR_S_MACK) begin
                nack_r <= sda_sync_r[1];
            end
        end else if (scl_fall) begin
            unique case (st_r)
                acr_pkg::ACR_S_IDLE: begin
                    sda_oe_n_o <= 1'b1;
                end
                acr_pkg::ACR_S_ADDR: begin
                    if (bit_r == 4'd8) begin
                        if (sh_r[7:1] == `ACR_SLAVE_ADDR) begin
                            rw_r <= sh_r[0];
                            sda_oe_n_o <= 1'b0;
                            st_r <= acr_pkg::ACR_S_ACK;
                        end else begin
                            st_r <= acr_pkg::ACR_S_IDLE;
                        end
                    end
                end
                acr_pkg::ACR_S_WDATA: begin
                    if (bit_r == 4'd8) begin
                        if (first_r) begin
                            index_r <= sh_r;
                        end else if (hi_r) begin
                            wr_hi_r <= sh_r;
                            hi_r <= 1'b0;
                        end else begin
                            hi_r <= 1'b1;
                        end
                        first_r <= 1'b0;
                        sda_oe_n_o <= 1'b0;
                        st_r <= acr_pkg::ACR_S_ACK;
                    end
                end
                acr_pkg::ACR_S_ACK: begin
                    bit_r <= 4'd0;
                    if (rw_r) begin
                        sh_r <= hi_r ? read_word[15:8] : read_word[7:0];
                        sda_oe_n_o <= hi_r ? read_word[15] : read_word[7];
                        hi_r <= !hi_r;
                        bit_r <= 4'd1;
                        st_r <= acr_pkg::ACR_S_RDATA;
                    end else begin
                        sda_oe_n_o <= 1'b1;
                        st_r <= acr_pkg::ACR_S_WDATA;
                    end
                end
                acr_pkg::ACR_S_RDATA: begin
                    if (bit_r == 4'd8) begin
                        sda_oe_n_o <= 1'b1;
                        st_r <= acr_pkg::ACR_S_MACK;
                    end else begin
                        sda_oe_n_o <= sh_r[3'(7 - bit_r)];
                        bit_r <= bit_r + 4'd1;
                    end
                end
                acr_pkg::ACR_S_MACK: begin
                    if (nack_r) begin
                        st_r <= acr_pkg::ACR_S_IDLE;
                    end else begin
                        sh_r <= hi_r ? read_word[15:8] : read_word[7:0];
                        sda_oe_n_o <= hi_r ? read_word[15] : read_word[7];
                        hi_r <= !hi_r;
                        bit_r <= 4'd1;
                        st_r <= acr_pkg::ACR_S_RDATA;
                    end
                end
            endcase
        end
    end

    // open drain: the pin is only ever pulled low
    always_ff @(posedge sys_clk_i) begin
        sda_o <= 1'b0;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic seen_done_r;
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            seen_done_r <= 1'b0;
        end else if (done_evt) begin
            seen_done_r <= 1'b1;
        end
    end

    result_low_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        result_r[3:0] == 4'h0)
        else $error("result low bits not zero");

    result_stays_zero_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !seen_done_r |-> result_r == 16'h0000)
        else $error("result changed before first conversion");

    setup_reset_value_a: assert property (
        @(posedge sys_clk_i)
        !reset_n_i |=> setup_word == `ACR_SETUP_RST)
        else $error("setup register reset value wrong");

    busy_start_ignored_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_setup && busy_r && !done_evt |=> busy_r && !req_r.start)
        else $error("start taken while busy");

    flag_continuous_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        setup_r.mode != `ACR_MODE_SINGLE |-> setup_word[15] == 1'b0)
        else $error("status flag set in continuous mode");

    flag_busy_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_setup && start_ok |=> setup_word[15] == 1'b0 [*2])
        else $error("status flag not cleared at start");

    write_ack_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        st_r == acr_pkg::ACR_S_ACK && !rw_r |-> !sda_oe_n_o)
        else $error("write byte not acknowledged");

    mux_fixed_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !HAS_MUX |-> setup_r.input_select == `ACR_MUX_FIXED)
        else $error("input select moved without multiplexer");

    index_kept_a: assert property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        rw_r && st_r != acr_pkg::ACR_S_ADDR |=> $stable(index_r))
        else $error("index changed during read");

    result_clip_a: assert property (
        @(posedge osc_clk_i) disable iff (!osc_rst_r[1])
        conv_end && signed'(sample_i) > signed'(16'h07ff) |=>
            osc_result_r == 16'h7ff0)
        else $error("positive overrange not clipped");

    single_done_c: cover property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        busy_r ##1 !busy_r);

    setup_write_c: cover property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_setup);

    continuous_done_c: cover property (
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        done_evt && setup_r.mode != `ACR_MODE_SINGLE);

endmodule

// ===== design/acr_cfg.svh
// offsets, field positions, reset values and timing figures of the block
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH

// register indices
`define ACR_IDX_RESULT 8'h00
`define ACR_IDX_SETUP 8'h01

// reset values
`define ACR_RESULT_RST 16'h0000
`define ACR_SETUP_RST 16'h8583

// setup register field positions
`define ACR_FLAG_BIT 15
`define ACR_MUX_HI 14
`define ACR_MUX_LO 12
`define ACR_GAIN_HI 11
`define ACR_GAIN_LO 9
`define ACR_MODE_BIT 8
`define ACR_RATE_HI 7
`define ACR_RATE_LO 5
`define ACR_RSVD_HI 4
`define ACR_RSVD_LO 0

// single-shot code of the mode bit, fixed mux code
`define ACR_MODE_SINGLE 1'b1
`define ACR_MUX_FIXED 3'h0

// result format
`define ACR_CODE_MAX 12'h7ff
`define ACR_CODE_MIN 12'h800
`define ACR_LOW_ZERO 4'h0

// link slave address
`define ACR_SLAVE_ADDR 7'h48

// data rates in samples per second
`define ACR_SPS_0 128
`define ACR_SPS_1 250
`define ACR_SPS_2 490
`define ACR_SPS_3 920
`define ACR_SPS_4 1600
`define ACR_SPS_5 2400
`define ACR_SPS_6 3300

// internal oscillator rate in hertz
`define ACR_OSC_HZ 12500000

`endif

// ===== design/acr_pkg.sv
// types shared by the converter control and result block
package acr_pkg;

    typedef enum logic [2:0] {
        ACR_S_IDLE,
        ACR_S_ADDR,
        ACR_S_ACK,
        ACR_S_WDATA,
        ACR_S_RDATA,
        ACR_S_MACK
    } acr_link_state_type;

    typedef struct packed {
        logic [2:0] input_select;
        logic [2:0] gain_range_select;
        logic mode;
        logic [2:0] sample_rate_select;
        logic [4:0] reserved;
    } acr_setup_type;

    typedef struct packed {
        logic start;
        logic mode;
        logic [2:0] sample_rate_select;
    } acr_request_type;

endpackage

// ===== tb/acr_link_master.sv
// behavioural serial-link master that drives the converter's pins
`timescale 1ns/10ps
module acr_link_master #(
    parameter int QTR = 10
) (
    input wire logic clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_drv_o
);
    // ----------------------------------------
    // bus idle: both lines released
    // ----------------------------------------
    initial begin
        scl_o = 1'b1;
        sda_drv_o = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // data moves only while the clock is low
    task automatic bit_cell(input logic b, output logic seen);
        sda_drv_o <= b;
        tick(QTR);
        scl_o <= 1'b1;
        tick(QTR);
        seen = sda_line_i;
        scl_o <= 1'b0;
        tick(QTR);
    endtask

    task automatic byte_io(input logic [7:0] tx, input logic last,
                           output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_cell(tx[i], rx[i]);
        end
        bit_cell(last, ack);
    endtask

    task automatic start_cond();
        sda_drv_o <= 1'b0;
        tick(QTR);
        scl_o <= 1'b0;
        tick(QTR);
    endtask

    task automatic stop_cond();
        sda_drv_o <= 1'b0;
        tick(QTR);
        scl_o <= 1'b1;
        tick(QTR);
        sda_drv_o <= 1'b1;
        tick(4 * QTR);
    endtask

    // ----------------------------------------
    // frames
    // ----------------------------------------
    task automatic write_frame(input logic [6:0] addr, input logic [7:0] idx,
                               input logic with_data, input logic [15:0] val,
                               output logic [3:0] acks);
        logic [7:0] rx;
        acks = 4'h0;
        start_cond();
        byte_io({addr, 1'b0}, 1'b1, rx, acks[3]);
        byte_io(idx, 1'b1, rx, acks[2]);
        if (with_data) begin
            byte_io(val[15:8], 1'b1, rx, acks[1]);
            byte_io(val[7:0], 1'b1, rx, acks[0]);
        end
        stop_cond();
    endtask

    // last byte refused so the slave lets go of the line
    task automatic read_frame(input logic [6:0] addr, output logic [15:0] w,
                              output logic ack);
        logic a;
        start_cond();
        byte_io({addr, 1'b1}, 1'b1, w[15:8], ack);
        byte_io(8'hff, 1'b0, w[15:8], a);
        byte_io(8'hff, 1'b1, w[7:0], a);
        stop_cond();
    endtask
endmodule

// ===== tb/acr_regs_tb.sv
// self-checking bench for the converter register block
`timescale 1ns/10ps
module acr_regs_tb;
    localparam logic [6:0] DEV = 7'h48;
    logic sys_clk, osc_clk, reset_n, scl, sda_drv, sda_out, sda_oe_n;
    logic sda_line;
    logic [15:0] sample;
    logic [2:0] in_sel, gain_sel;
    logic [2:0] fixed_sel;
    int num_errors;
    int comparisons;

    // open-drain line with pull-up
    assign sda_line = sda_drv & (sda_oe_n | sda_out);

    acr_regs #(.HAS_MUX(1'b1), .OSC_HZ(128000)) i_dut (
        .sys_clk_i(sys_clk),
        .reset_n_i(reset_n),
        .osc_clk_i(osc_clk),
        .sample_i(sample),
        .scl_i(scl),
        .sda_i(sda_line),
        .sda_o(sda_out),
        .sda_oe_n_o(sda_oe_n),
        .input_select_o(in_sel),
        .gain_range_select_o(gain_sel)
    );

    // variant without multiplexer listens on the line but never answers
    acr_regs #(.HAS_MUX(1'b0), .OSC_HZ(128000)) i_dut_fixed (
        .sys_clk_i(sys_clk),
        .reset_n_i(reset_n),
        .osc_clk_i(osc_clk),
        .sample_i(sample),
        .scl_i(scl),
        .sda_i(sda_line),
        .sda_o(),
        .sda_oe_n_o(),
        .input_select_o(fixed_sel),
        .gain_range_select_o()
    );

    acr_link_master i_master (
        .clk_i(sys_clk),
        .sda_line_i(sda_line),
        .scl_o(scl),
        .sda_drv_o(sda_drv)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        osc_clk = 1'b0;
        #13;
        forever #40 osc_clk = ~osc_clk;
    end

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] setup(input logic st, input logic [2:0] mx,
            input logic [2:0] gn, input logic md, input logic [2:0] rt);
        return {st, mx, gn, md, rt, 5'h03};
    endfunction

    task automatic wr(input logic [7:0] idx, input logic [15:0] val);
        logic [3:0] acks;
        i_master.write_frame(DEV, idx, 1'b1, val, acks);
        check("write acks", {12'h0, acks}, 16'h0000);
    endtask

    task automatic wr_idx(input logic [7:0] idx);
        logic [3:0] acks;
        i_master.write_frame(DEV, idx, 1'b0, 16'h0000, acks);
        check("index acks", {14'h0, acks[3:2]}, 16'h0000);
    endtask

    task automatic rd_cur(output logic [15:0] w);
        logic ack;
        i_master.read_frame(DEV, w, ack);
        check("read ack", {15'h0, ack}, 16'h0000);
    endtask

    task automatic set_sample(input logic [15:0] v);
        @(posedge osc_clk);
        sample <= v;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [15:0] w;
        check("gain pins", {13'h0, gain_sel}, 16'h0002);
        check("mux pins", {13'h0, in_sel}, 16'h0000);
        rd_cur(w);
        check("result reset", w, 16'h0000);
        wr_idx(8'h01);
        rd_cur(w);
        check("setup reset", w, 16'h8583);
        rd_cur(w);
        check("index kept", w, 16'h8583);
    endtask

    // every code of the three fields; start bit 0 starts nothing
    task automatic t_fields();
        logic [15:0] w;
        for (int i = 0; i < 8; i++) begin
            wr(8'h01, setup(1'b0, 3'(i), 3'(i), 1'b1, 3'(i)));
            check("mux pins", {13'h0, in_sel}, 16'(i));
            check("gain pins", {13'h0, gain_sel}, 16'(i));
            check("fixed mux", {13'h0, fixed_sel}, 16'h0000);
            rd_cur(w);
            check("setup back", w, setup(1'b1, 3'(i), 3'(i), 1'b1, 3'(i)));
        end
    endtask

    task automatic t_single();
        logic [15:0] w;
        int n;
        set_sample(16'h0123);
        wr(8'h01, setup(1'b1, 3'h0, 3'h2, 1'b1, 3'h0));
        rd_cur(w);
        check("busy flag", {15'h0, w[15]}, 16'h0000);
        // a second start while converting must neither restart nor stall it
        wr(8'h01, setup(1'b1, 3'h0, 3'h2, 1'b1, 3'h0));
        rd_cur(w);
        check("still busy", {15'h0, w[15]}, 16'h0000);
        n = 0;
        while (w[15] !== 1'b1) begin
            n++;
            if (n > 40) begin
                num_errors++;
                finish_test();
            end
            rd_cur(w);
        end
        check("idle setup", w, setup(1'b1, 3'h0, 3'h2, 1'b1, 3'h0));
        wr_idx(8'h00);
        rd_cur(w);
        check("result", w, 16'h1230);
    endtask

    // the index frame outlasts a 3300 per second conversion
    task automatic t_clip();
        logic [15:0] w;
        logic [15:0] raw [5] = '{16'h07ff, 16'h0800, 16'hf800, 16'hf7ff,
                                 16'hffff};
        logic [15:0] exp [5] = '{16'h7ff0, 16'h7ff0, 16'h8000, 16'h8000,
                                 16'hfff0};
        for (int i = 0; i < 5; i++) begin
            set_sample(raw[i]);
            wr(8'h01, setup(1'b1, 3'h0, 3'h2, 1'b1, 3'h6));
            wr_idx(8'h00);
            rd_cur(w);
            check("clipped result", w, exp[i]);
        end
        set_sample(16'h0001);
        wr(8'h01, setup(1'b0, 3'h0, 3'h2, 1'b1, 3'h6));
        wr_idx(8'h00);
        rd_cur(w);
        check("no start", w, 16'hfff0);
    endtask

    task automatic t_cont();
        logic [15:0] w;
        set_sample(16'h0010);
        wr(8'h01, setup(1'b1, 3'h0, 3'h2, 1'b0, 3'h6));
        rd_cur(w);
        check("cont setup", w, setup(1'b0, 3'h0, 3'h2, 1'b0, 3'h6));
        wr_idx(8'h00);
        rd_cur(w);
        check("cont result", w, 16'h0100);
        set_sample(16'h0020);
        rd_cur(w);
        rd_cur(w);
        check("cont update", w, 16'h0200);
        wr(8'h01, setup(1'b0, 3'h0, 3'h2, 1'b1, 3'h4));
        rd_cur(w);
        check("back single", w, 16'h8583);
    endtask

    task automatic t_refuse();
        logic [15:0] w;
        logic [3:0] acks;
        i_master.write_frame(7'h49, 8'h01, 1'b0, 16'h0000, acks);
        check("foreign addr", {12'h0, acks}, 16'h000c);
        wr(8'h00, 16'h5555);
        rd_cur(w);
        check("result ro", w, 16'h0200);
        wr_idx(8'h02);
        rd_cur(w);
        check("unmapped", w, 16'h0000);
        wr_idx(8'h01);
        rd_cur(w);
        check("setup kept", w, 16'h8583);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        num_errors = 0;
        comparisons = 0;
        reset_n = 1'b0;
        sample = 16'h0000;
        // long enough for the slow domain to see reset too
        repeat (30) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        t_reset();
        t_fields();
        t_single();
        t_clip();
        t_cont();
        t_refuse();
        finish_test();
    end
endmodule
